// *** include/alarm_monitor_defines.svh ***
// Register offsets, reset values and bit masks of the alarm latch and monitor group
`ifndef ALARM_MONITOR_DEFINES_SVH
`define ALARM_MONITOR_DEFINES_SVH

`define ADDR_STATE_LATCH        16'ha022
`define ADDR_GENERAL_LATCH      16'ha023
`define ADDR_FAULT_LATCH        16'ha024
`define ADDR_AW1_LATCH          16'ha025
`define ADDR_AW2_LATCH          16'ha026
`define ADDR_VENDOR_LATCH       16'ha027
`define ADDR_STATE_ENABLE       16'ha028
`define ADDR_GENERAL_ENABLE     16'ha029
`define ADDR_FAULT_ENABLE       16'ha02a
`define ADDR_AW1_ENABLE         16'ha02b
`define ADDR_AW2_ENABLE         16'ha02c
`define ADDR_VENDOR_ENABLE      16'ha02d
`define ADDR_TEMPERATURE        16'ha02f
`define ADDR_SUPPLY             16'ha030
`define ADDR_BIAS               16'ha031
`define ADDR_AUX1               16'ha032
`define ADDR_AUX2               16'ha033
`define ADDR_NET_BIT_COUNT      16'ha038
`define ADDR_HOST_BIT_COUNT     16'ha039

`define RST_STATE_ENABLE        16'h006a
`define RST_GENERAL_ENABLE      16'ha7f8
`define RST_FAULT_ENABLE        16'h0062
`define RST_AW1_ENABLE          16'h0fff
`define RST_AW2_ENABLE          16'h00ff
`define RST_VENDOR_ENABLE       16'h0000
`define RST_WORD                16'h0000

// Writable bits of each enable register
`define WR_STATE_ENABLE         16'h01fe
`define WR_GENERAL_ENABLE       16'ha7f8
`define WR_FAULT_ENABLE         16'h0062
`define WR_AW1_ENABLE           16'h0fff
`define WR_AW2_ENABLE           16'h00ff
`define WR_VENDOR_ENABLE        16'hffff

// Implemented source bits of the general, fault and alarm/warning latch registers
`define SRC_GENERAL             16'h27f8
`define SRC_FAULT               16'h0062
`define SRC_AW1                 16'h0fff
`define SRC_AW2                 16'h00ff
`define ANYEDGE_GENERAL         16'h00f0
`define MASTER_ENABLE_BIT       15
`define GENERAL_LOCAL_MSB       14

`define FLOAT_MANT_W            10
`define FLOAT_EXP_W             6
`define BIAS_COHERENT_SHIFT     2
`define TYPE_COHERENT_A         8'h02
`define TYPE_COHERENT_B         8'h10
`define TYPE_COHERENT_C         8'h11

`endif

// *** include/alarm_monitor_pkg.sv ***
// Shared types of the alarm latch and monitor group
package alarm_monitor_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [3:0] {
      ST_INITIALIZE,
      ST_LOW_POWER,
      ST_HIGH_POWER_UP,
      ST_TX_OFF,
      ST_TX_TURN_ON,
      ST_READY,
      ST_FAULT,
      ST_TX_TURN_OFF,
      ST_HIGH_POWER_DOWN
   } module_state_e;
endpackage

// *** design/event_latch.sv ***
// Sticky latch register with per-bit level or any-edge set and clear on read
`timescale 1ns/1ps
module event_latch #(
   parameter int          WIDTH     = 16,
   parameter logic [15:0] SRC_MASK  = 16'hffff,
   parameter logic [15:0] EDGE_MASK = 16'h0000
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] source,
   input  wire logic             clearPulse,
   output logic      [WIDTH-1:0] latched
);
   logic [WIDTH-1:0] prevQ;
   logic [WIDTH-1:0] setEvent;
   logic [WIDTH-1:0] latchQ;
   logic [WIDTH-1:0] latchD;

   always_comb
   begin
      setEvent = ((source & ~EDGE_MASK[WIDTH-1:0]) | ((source ^ prevQ) & EDGE_MASK[WIDTH-1:0]))
                 & SRC_MASK[WIDTH-1:0];
      // A set arriving with the read clear still wins
      latchD   = (clearPulse ? '0 : latchQ) | setEvent;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         prevQ <= '0;
      else
         prevQ <= source;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         latchQ <= '0;
      else
         latchQ <= latchD;
   end

   assign latched = latchQ;
endmodule

// *** design/pattern_bit_counter.sv ***
// Checked-bit counter reported as 6-bit exponent and 10-bit mantissa
`timescale 1ns/1ps
`include "alarm_monitor_defines.svh"
module pattern_bit_counter #(
   parameter int BITS_PER_CYCLE = 32
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        checkerEnable,
   output logic      [15:0] floatCount
);
   logic [63:0] totalQ;
   logic        enablePrevQ;
   logic [15:0] floatQ;

   function automatic logic [15:0] toFloat(input logic [63:0] v);
      int          msb;
      logic [63:0] shifted;
      logic [5:0]  expo;
      msb = 0;
      for (int i = 0; i < 64; i++)
         if (v[i])
            msb = i;
      if (msb < `FLOAT_MANT_W)
      begin
         expo = '0;
      end
      else
      begin
         expo = 6'(msb - (`FLOAT_MANT_W - 1));
      end
      shifted = v >> expo;
      return {expo, shifted[`FLOAT_MANT_W-1:0]};
   endfunction

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         enablePrevQ <= 1'b0;
      else
         enablePrevQ <= checkerEnable;
   end

   // Restart on enable, saturate instead of wrapping
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         totalQ <= '0;
      else if (checkerEnable && !enablePrevQ)
         totalQ <= 64'(BITS_PER_CYCLE);
      else if (checkerEnable && (totalQ <= ~64'(BITS_PER_CYCLE)))
         totalQ <= totalQ + 64'(BITS_PER_CYCLE);
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         floatQ <= `RST_WORD;
      else
         floatQ <= toFloat(totalQ);
   end

   assign floatCount = floatQ;
endmodule

// *** design/alarm_latch_monitor.sv ***
// Module alarm latches, alarm enables, global alarm and monitor readback
//
// Operation
// RULE_01: Latch bit set on entering each state
// RULE_02: Fault, alarm, warning latches hold once set
// RULE_03: Four lock/signal latches set on any change
// RULE_04: State enable register, reset value 006Ah
// RULE_05: Fault/ready/off/low-power enables reset to one
// RULE_06: General enables 14..0 gate general latches
// RULE_07: Bit 15 master enable gates global alarm
// RULE_08: Fault enables gate fault latches, reset 0062h
// RULE_09: Alarm/warning enables gate latches, reset 0FFFh/00FFh
// RULE_10: Unimplemented feature enables forced to zero
// RULE_11: Vendor latch and enable, reset zero
// RULE_12: Temperature signed, 1/256 degree steps
// RULE_13: Supply unsigned, 0.1 mV steps
// RULE_14: Bias 2 uA steps, 8 uA coherent
// RULE_15: Auxiliary 1 high byte at low address
// RULE_16: Network count runs only with checker
// RULE_17: Host count runs only with checker
// RULE_18: Counts as exponent 15..10, mantissa 9..0
// RULE_19: Any fatal fault requests fault state
// RULE_20: Summary flags OR enabled latch bits
// RULE_21: Latch read returns then clears bits
// RULE_22: Read-only enable bits ignore writes
// RULE_23: Global alarm follows changes in one cycle
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "alarm_monitor_defines.svh"
module alarm_latch_monitor
   import alarm_monitor_pkg::*;
#(
   parameter logic [15:0] FEATURE_GENERAL = 16'hffff,
   parameter logic [15:0] FEATURE_FAULT   = 16'hffff,
   parameter logic [15:0] FEATURE_AW1     = 16'hffff,
   parameter logic [15:0] FEATURE_AW2     = 16'hffff,
   parameter int          NET_BITS_PER_CYCLE  = 32,
   parameter int          HOST_BITS_PER_CYCLE = 32
) (
   input  wire logic                                ref_clk,
   input  wire logic                                rst_b,
   input  wire logic [15:0]                         regAddr,
   input  wire logic [15:0]                         regWrData,
   input  wire logic                                regWrStrobe,
   input  wire logic                                regRdStrobe,
   output logic      [15:0]                         regRdData,
   input  wire alarm_monitor_pkg::module_state_e    moduleState,
   input  wire alarm_monitor_pkg::word_t            generalStatus,
   input  wire alarm_monitor_pkg::word_t            faultStatus,
   input  wire alarm_monitor_pkg::word_t            alarmWarnGroup1,
   input  wire alarm_monitor_pkg::word_t            alarmWarnGroup2,
   input  wire alarm_monitor_pkg::word_t            vendorStatus,
   input  wire logic [15:0]                         temperatureRaw,
   input  wire logic [15:0]                         supplyRaw,
   input  wire logic [17:0]                         biasRaw,
   input  wire logic [7:0]                          moduleTypeCode,
   input  wire logic [15:0]                         aux1Raw,
   input  wire logic [15:0]                         aux2Raw,
   input  wire logic                                networkCheckerEnable,
   input  wire logic                                hostCheckerEnable,
   output logic                                     global_alarm_output,
   output logic                                     faultStateRequest,
   output logic      [5:0]                          summaryFlags
);
   word_t statePresent;
   module_state_e statePrevQ;
   word_t stateLatch;
   word_t generalLatch;
   word_t faultLatch;
   word_t aw1Latch;
   word_t aw2Latch;
   word_t vendorLatch;
   word_t stateEnableQ;
   word_t generalEnableQ;
   word_t faultEnableQ;
   word_t aw1EnableQ;
   word_t aw2EnableQ;
   word_t vendorEnableQ;
   word_t temperatureQ;
   word_t supplyQ;
   word_t biasQ;
   word_t aux1Q;
   word_t aux2Q;
   word_t netCount;
   word_t hostCount;
   word_t readMux;
   word_t rdDataQ;
   logic  isCoherent;
   logic  alarmQ;
   logic  faultReqQ;
   logic [5:0] summaryD;
   logic [5:0] summaryQ;
   logic       clrState;
   logic       clrGeneral;
   logic       clrFault;
   logic       clrAw1;
   logic       clrAw2;
   logic       clrVendor;

   // New enable value: only writable, implemented bits change
   function automatic word_t enableWrite(input word_t oldVal, input word_t wrVal, input word_t wrMask,
                                         input word_t feature);
      return ((oldVal & ~wrMask) | (wrVal & wrMask)) & feature;
   endfunction

   function automatic logic readHit(input logic [15:0] addr, input logic [15:0] target);
      return regRdStrobe && (addr == target);
   endfunction

   function automatic logic writeHit(input logic [15:0] addr, input logic [15:0] target);
      return regWrStrobe && (addr == target);
   endfunction

   // RULE_01: one-hot current state
   always_comb
   begin
      statePresent = '0;
      statePresent[moduleState] = 1'b1;
   end

   // Entry only: leaving a state must not set its bit
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         statePrevQ <= ST_INITIALIZE;
      else
         statePrevQ <= moduleState;
   end

   // RULE_21: clear pulses on read
   always_comb
   begin
      clrState   = readHit(regAddr, `ADDR_STATE_LATCH);
      clrGeneral = readHit(regAddr, `ADDR_GENERAL_LATCH);
      clrFault   = readHit(regAddr, `ADDR_FAULT_LATCH);
      clrAw1     = readHit(regAddr, `ADDR_AW1_LATCH);
      clrAw2     = readHit(regAddr, `ADDR_AW2_LATCH);
      clrVendor  = readHit(regAddr, `ADDR_VENDOR_LATCH);
   end

   // RULE_01: set on state entry
   event_latch #(.WIDTH(16), .SRC_MASK(16'h01ff)) stateLatchInst (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .source     ((moduleState != statePrevQ) ? statePresent : '0),
      .clearPulse (clrState),
      .latched    (stateLatch)
   );

   // RULE_03: any-change bits 7..4
   event_latch #(.WIDTH(16), .SRC_MASK(`SRC_GENERAL), .EDGE_MASK(`ANYEDGE_GENERAL)) generalLatchInst (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .source     (generalStatus),
      .clearPulse (clrGeneral),
      .latched    (generalLatch)
   );

   // RULE_02: level-set sticky latches
   event_latch #(.WIDTH(16), .SRC_MASK(`SRC_FAULT)) faultLatchInst (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .source     (faultStatus),
      .clearPulse (clrFault),
      .latched    (faultLatch)
   );

   event_latch #(.WIDTH(16), .SRC_MASK(`SRC_AW1)) aw1LatchInst (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .source     (alarmWarnGroup1),
      .clearPulse (clrAw1),
      .latched    (aw1Latch)
   );

   event_latch #(.WIDTH(16), .SRC_MASK(`SRC_AW2)) aw2LatchInst (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .source     (alarmWarnGroup2),
      .clearPulse (clrAw2),
      .latched    (aw2Latch)
   );

   // RULE_11: vendor latch, all bits usable
   event_latch #(.WIDTH(16)) vendorLatchInst (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .source     (vendorStatus),
      .clearPulse (clrVendor),
      .latched    (vendorLatch)
   );

   // RULE_04: state enables, RULE_05 defaults
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         stateEnableQ <= `RST_STATE_ENABLE;
      else if (writeHit(regAddr, `ADDR_STATE_ENABLE))
         stateEnableQ <= enableWrite(stateEnableQ, regWrData, `WR_STATE_ENABLE, 16'hffff);
   end

   // RULE_10: unimplemented features forced low
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         generalEnableQ <= `RST_GENERAL_ENABLE & FEATURE_GENERAL;
      else if (writeHit(regAddr, `ADDR_GENERAL_ENABLE))
         generalEnableQ <= enableWrite(generalEnableQ, regWrData, `WR_GENERAL_ENABLE, FEATURE_GENERAL);
   end

   // RULE_08: fault enables
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         faultEnableQ <= `RST_FAULT_ENABLE & FEATURE_FAULT;
      else if (writeHit(regAddr, `ADDR_FAULT_ENABLE))
         faultEnableQ <= enableWrite(faultEnableQ, regWrData, `WR_FAULT_ENABLE, FEATURE_FAULT);
   end

   // RULE_09: alarm and warning enables
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw1EnableQ <= `RST_AW1_ENABLE & FEATURE_AW1;
         aw2EnableQ <= `RST_AW2_ENABLE & FEATURE_AW2;
      end
      else
      begin
         if (writeHit(regAddr, `ADDR_AW1_ENABLE))
            aw1EnableQ <= enableWrite(aw1EnableQ, regWrData, `WR_AW1_ENABLE, FEATURE_AW1);
         if (writeHit(regAddr, `ADDR_AW2_ENABLE))
            aw2EnableQ <= enableWrite(aw2EnableQ, regWrData, `WR_AW2_ENABLE, FEATURE_AW2);
      end
   end

   // RULE_11: vendor enable
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         vendorEnableQ <= `RST_VENDOR_ENABLE;
      else if (writeHit(regAddr, `ADDR_VENDOR_ENABLE))
         vendorEnableQ <= enableWrite(vendorEnableQ, regWrData, `WR_VENDOR_ENABLE, 16'hffff);
   end

   // RULE_20: per-group summaries
   always_comb
   begin
      summaryD[0] = |(stateLatch & stateEnableQ);
      summaryD[1] = |(generalLatch[`GENERAL_LOCAL_MSB:0] & generalEnableQ[`GENERAL_LOCAL_MSB:0]);
      summaryD[2] = |(faultLatch & faultEnableQ);
      summaryD[3] = |(aw1Latch & aw1EnableQ);
      summaryD[4] = |(aw2Latch & aw2EnableQ);
      summaryD[5] = |(vendorLatch & vendorEnableQ);
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         summaryQ <= '0;
      else
         summaryQ <= summaryD;
   end

   // RULE_06: RULE_07 master gate, RULE_23 one flop
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         alarmQ <= 1'b0;
      else
         alarmQ <= generalEnableQ[`MASTER_ENABLE_BIT] & (|summaryD);
   end

   // RULE_19: fatal fault requests fault state
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         faultReqQ <= 1'b0;
      else
         faultReqQ <= |(faultStatus & `SRC_FAULT);
   end

   // RULE_14: coherent type reports 8 uA steps
   always_comb
   begin
      isCoherent = (moduleTypeCode == `TYPE_COHERENT_A) || (moduleTypeCode == `TYPE_COHERENT_B)
                   || (moduleTypeCode == `TYPE_COHERENT_C);
   end

   // RULE_12: RULE_13 RULE_15 monitor capture
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         temperatureQ <= `RST_WORD;
         supplyQ      <= `RST_WORD;
         biasQ        <= `RST_WORD;
         aux1Q        <= `RST_WORD;
         aux2Q        <= `RST_WORD;
      end
      else
      begin
         temperatureQ <= temperatureRaw;
         supplyQ      <= supplyRaw;
         // Clamp rather than wrap a 2 uA value above full scale
         if (isCoherent)
            biasQ <= 16'(biasRaw >> `BIAS_COHERENT_SHIFT);
         else if (|biasRaw[17:16])
            biasQ <= 16'hffff;
         else
            biasQ <= biasRaw[15:0];
         aux1Q <= aux1Raw;
         aux2Q <= aux2Raw;
      end
   end

   // RULE_16: RULE_18 network count
   pattern_bit_counter #(.BITS_PER_CYCLE(NET_BITS_PER_CYCLE)) netCounterInst (
      .ref_clk       (ref_clk),
      .rst_b         (rst_b),
      .checkerEnable (networkCheckerEnable),
      .floatCount    (netCount)
   );

   // RULE_17: host count
   pattern_bit_counter #(.BITS_PER_CYCLE(HOST_BITS_PER_CYCLE)) hostCounterInst (
      .ref_clk       (ref_clk),
      .rst_b         (rst_b),
      .checkerEnable (hostCheckerEnable),
      .floatCount    (hostCount)
   );

   // RULE_22: fixed bits read from masked storage
   always_comb
   begin
      case (regAddr)
         `ADDR_STATE_LATCH:    readMux = stateLatch;
         `ADDR_GENERAL_LATCH:  readMux = generalLatch;
         `ADDR_FAULT_LATCH:    readMux = faultLatch;
         `ADDR_AW1_LATCH:      readMux = aw1Latch;
         `ADDR_AW2_LATCH:      readMux = aw2Latch;
         `ADDR_VENDOR_LATCH:   readMux = vendorLatch;
         `ADDR_STATE_ENABLE:   readMux = stateEnableQ;
         `ADDR_GENERAL_ENABLE: readMux = generalEnableQ;
         `ADDR_FAULT_ENABLE:   readMux = faultEnableQ;
         `ADDR_AW1_ENABLE:     readMux = aw1EnableQ;
         `ADDR_AW2_ENABLE:     readMux = aw2EnableQ;
         `ADDR_VENDOR_ENABLE:  readMux = vendorEnableQ;
         `ADDR_TEMPERATURE:    readMux = temperatureQ;
         `ADDR_SUPPLY:         readMux = supplyQ;
         `ADDR_BIAS:           readMux = biasQ;
         `ADDR_AUX1:           readMux = aux1Q;
         `ADDR_AUX2:           readMux = aux2Q;
         `ADDR_NET_BIT_COUNT:  readMux = netCount;
         `ADDR_HOST_BIT_COUNT: readMux = hostCount;
         default:              readMux = `RST_WORD;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         rdDataQ <= `RST_WORD;
      else if (regRdStrobe)
         rdDataQ <= readMux;
      else
         rdDataQ <= `RST_WORD;
   end

   assign regRdData           = rdDataQ;
   assign global_alarm_output = alarmQ;
   assign faultStateRequest   = faultReqQ;
   assign summaryFlags        = summaryQ;
endmodule

// *** sim/alarm_latch_monitor_asserts.sv ***
// Port-level assertions for the alarm latch and monitor group
`timescale 1ns/1ps
module alarm_latch_monitor_asserts
   import alarm_monitor_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   input  wire logic [15:0]              regAddr,
   input  wire logic                     regRdStrobe,
   input  wire logic [15:0]              regRdData,
   input  wire alarm_monitor_pkg::word_t faultStatus,
   input  wire logic [15:0]              temperatureRaw,
   input  wire logic [15:0]              supplyRaw,
   input  wire logic [17:0]              biasRaw,
   input  wire logic [7:0]               moduleTypeCode,
   input  wire logic [15:0]              aux1Raw,
   input  wire logic                     global_alarm_output,
   input  wire logic                     faultStateRequest,
   input  wire logic [5:0]               summaryFlags
);
   logic fatalNow;
   logic coherent;
   assign fatalNow = |(faultStatus & 16'h0062);
   assign coherent = moduleTypeCode == 8'h02 || moduleTypeCode == 8'h10 || moduleTypeCode == 8'h11;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_rd(logic [15:0] a);
      regRdStrobe && regAddr == a;
   endsequence

   chk_rd_data_window: assert property (!regRdStrobe |=> regRdData == 16'h0000)
      else $error("read data seen outside its cycle");
   chk_temp_readback: assert property (s_rd(16'ha02f) |=> regRdData == $past(temperatureRaw, 2))
      else $error("temperature readback wrong");
   chk_supply_readback: assert property (s_rd(16'ha030) |=> regRdData == $past(supplyRaw, 2))
      else $error("supply readback wrong");
   chk_bias_coherent_scale: assert property (s_rd(16'ha031) ##0 $past(coherent)
      |=> regRdData == 16'($past(biasRaw, 2) >> 2))
      else $error("coherent bias step wrong");
   chk_aux1_byte_order: assert property (s_rd(16'ha032) |=> regRdData == $past(aux1Raw, 2))
      else $error("auxiliary 1 byte order wrong");
   chk_reserved_reads_zero: assert property (s_rd(16'ha02e) or s_rd(16'ha034) |=> regRdData == 16'h0000)
      else $error("reserved address returned data");
   chk_fatal_fault_request: assert property ($changed(fatalNow) |=> faultStateRequest == $past(fatalNow))
      else $error("fault state request does not follow fatal faults");
   chk_alarm_has_cause: assert property (global_alarm_output |-> summaryFlags != 6'h00)
      else $error("global alarm without an enabled latch");
endmodule

bind alarm_latch_monitor alarm_latch_monitor_asserts u_alarm_latch_monitor_asserts (
   .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
   .faultStatus(faultStatus), .temperatureRaw(temperatureRaw), .supplyRaw(supplyRaw), .biasRaw(biasRaw),
   .moduleTypeCode(moduleTypeCode), .aux1Raw(aux1Raw), .global_alarm_output(global_alarm_output),
   .faultStateRequest(faultStateRequest), .summaryFlags(summaryFlags));

// *** sim/host_reg_master.sv ***
// Host-side master of the strobe register bus
`timescale 1ns/1ps
module host_reg_master (
   input  wire logic        ref_clk,
   output logic      [15:0] regAddr,
   output logic      [15:0] regWrData,
   output logic             regWrStrobe,
   output logic             regRdStrobe,
   input  wire logic [15:0] regRdData
);
   initial
   begin
      regAddr = 16'h0000;
      regWrData = 16'h0000;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
   end

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge ref_clk);
      regWrStrobe <= 1'b0;
      // Idle data is not left at the last word
      regWrData <= ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge ref_clk);
      regRdStrobe <= 1'b0;
      #1 d = regRdData;
   endtask
endmodule

// *** sim/test_module_alarm_latch_enable_monitor.sv ***
// Self-checking bench for the alarm latch and monitor group
`timescale 1ns/1ps
module test_module_alarm_latch_enable_monitor;
   import alarm_monitor_pkg::*;
   logic           ref_clk, rst_b, wrS, rdS, netEn, hostEn, alarm, fatalReq;
   logic [15:0]    addr, wdat, rdat, temp, supply, aux1, aux2;
   logic [17:0]    bias;
   logic [7:0]     typeCode;
   logic [5:0]     flags;
   module_state_e  state;
   word_t          gen, fault, aw1, aw2, vend;
   int             n_errors, compares, cycles;
   logic [15:0]    enAddr [6] = '{16'ha028, 16'ha029, 16'ha02a, 16'ha02b, 16'ha02c, 16'ha02d};
   logic [15:0]    enRst  [6] = '{16'h006a, 16'ha7f8, 16'h0062, 16'h0fff, 16'h00ff, 16'h0000};
   logic [15:0]    enWr   [6] = '{16'h01fe, 16'ha7f8, 16'h0062, 16'h0fff, 16'h00ff, 16'hffff};

   alarm_latch_monitor u_alarm_latch_monitor (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(addr), .regWrData(wdat),
      .regWrStrobe(wrS), .regRdStrobe(rdS), .regRdData(rdat), .moduleState(state), .generalStatus(gen),
      .faultStatus(fault), .alarmWarnGroup1(aw1), .alarmWarnGroup2(aw2), .vendorStatus(vend),
      .temperatureRaw(temp), .supplyRaw(supply), .biasRaw(bias), .moduleTypeCode(typeCode), .aux1Raw(aux1),
      .aux2Raw(aux2), .networkCheckerEnable(netEn), .hostCheckerEnable(hostEn), .global_alarm_output(alarm),
      .faultStateRequest(fatalReq), .summaryFlags(flags));
   host_reg_master u_host_reg_master (.ref_clk(ref_clk), .regAddr(addr), .regWrData(wdat), .regWrStrobe(wrS),
      .regRdStrobe(rdS), .regRdData(rdat));

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic results();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A hang ends the run as a failure
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_errors++;
         results();
      end
   end

   task automatic cmp16(input logic [15:0] exp, input logic [15:0] got, input logic [15:0] a);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: addr %h read %h expected %h", $time, a, got, exp);
      end
   endtask

   task automatic cmp1(input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: alarm %b expected %b", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      u_host_reg_master.rd(a, d);
      cmp16(exp, d, a);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   initial
   begin
      {rst_b, netEn, hostEn, gen, fault, aw1, aw2, vend, bias, typeCode} = '0;
      {temp, supply, aux1, aux2} = {16'hec00, 16'h8214, 16'h12ab, 16'h5a3c};
      state = ST_INITIALIZE;
      n_errors = 0;
      compares = 0;
      cycles = 0;
      tick(2);
      rst_b <= 1'b1;
      for (int j = 0; j < 6; j++) rdc(16'ha022 + 16'(j), 16'h0000);
      rdc(16'ha038, 16'h0000);
      rdc(16'ha039, 16'h0000);
      for (int i = 0; i < 6; i++) rdc(enAddr[i], enRst[i]);
      for (int i = 0; i < 6; i++)
      begin
         u_host_reg_master.wr(enAddr[i], 16'hffff);
         rdc(enAddr[i], enWr[i]);
         u_host_reg_master.wr(enAddr[i], enRst[i]);
      end
      // Short fault pulse must stick and drive the alarm
      fault <= 16'h0020;
      tick(1);
      fault <= 16'h0000;
      tick(1);
      #1 cmp1(1'b1, alarm);
      rdc(16'ha024, 16'h0020);
      rdc(16'ha024, 16'h0000);
      cmp1(1'b0, alarm);
      @(posedge ref_clk) fault <= 16'h0002;
      tick(2);
      rdc(16'ha024, 16'h0002);
      cmp1(1'b1, fatalReq);
      rdc(16'ha024, 16'h0002);
      fault <= 16'h0000;
      rdc(16'ha024, 16'h0002);
      for (int b = 4; b < 8; b++)
      begin
         @(posedge ref_clk) gen <= 16'h0001 << b;
         tick(2);
         rdc(16'ha023, 16'h0001 << b);
         rdc(16'ha023, 16'h0000);
         gen <= 16'h0000;
         tick(2);
         rdc(16'ha023, 16'h0001 << b);
      end
      for (int s = 1; s < 10; s++)
      begin
         @(posedge ref_clk) state <= module_state_e'(s % 9);
         tick(2);
         rdc(16'ha022, 16'h0001 << (s % 9));
      end
      u_host_reg_master.wr(16'ha029, 16'h27f8);
      aw1 <= 16'h0001;
      tick(3);
      #1 cmp1(1'b0, alarm);
      cmp1(1'b1, flags[3]);
      u_host_reg_master.wr(16'ha029, 16'ha7f8);
      tick(1);
      #1 cmp1(1'b1, alarm);
      u_host_reg_master.wr(16'ha02b, 16'h0ffe);
      tick(1);
      #1 cmp1(1'b0, alarm);
      u_host_reg_master.wr(16'ha02b, 16'h0fff);
      aw1 <= 16'h0000;
      rdc(16'ha025, 16'h0001);
      @(posedge ref_clk) aw2 <= 16'h0080;
      vend <= 16'h0001;
      @(posedge ref_clk) aw2 <= 16'h0000;
      rdc(16'ha026, 16'h0080);
      rdc(16'ha027, 16'h0001);
      vend <= 16'h0000;
      rdc(16'ha027, 16'h0001);
      cmp1(1'b0, alarm);
      u_host_reg_master.wr(16'ha02f, 16'h0000);
      rdc(16'ha02f, 16'hec00);
      rdc(16'ha030, 16'h8214);
      rdc(16'ha032, 16'h12ab);
      rdc(16'ha033, 16'h5a3c);
      u_host_reg_master.wr(16'ha02e, 16'hffff);
      rdc(16'ha02e, 16'h0000);
      rdc(16'ha034, 16'h0000);
      bias <= 18'h00123;
      rdc(16'ha031, 16'h0123);
      bias <= 18'h01234;
      foreach (enWr[k]) if (k < 3)
      begin
         typeCode <= (k == 0) ? 8'h02 : ((k == 1) ? 8'h10 : 8'h11);
         rdc(16'ha031, 16'h048d);
      end
      @(posedge ref_clk) netEn <= 1'b1;
      tick(10);
      netEn <= 1'b0;
      tick(3);
      rdc(16'ha038, 16'h0140);
      tick(5);
      rdc(16'ha038, 16'h0140);
      @(posedge ref_clk) hostEn <= 1'b1;
      tick(40);
      hostEn <= 1'b0;
      tick(3);
      rdc(16'ha039, 16'h0680);
      rdc(16'ha039, 16'h0680);
      results();
   end
endmodule
